// ---- pkg/phy_diag_pkg.sv ----
// Shared constants and types for the strap, LED and diagnostic block
package phy_diag_pkg;
  localparam int CLK_HZ = 10_000_000;
  // Management register offsets
  localparam logic [4:0] REG_BASIC_MODE = 5'h00;
  localparam logic [4:0] REG_STATUS     = 5'h10;
  localparam logic [4:0] REG_LED_OVR    = 5'h18;
  localparam logic [4:0] REG_PHY_CTRL   = 5'h19;
  localparam logic [4:0] REG_DIAG       = 5'h1B;
  // Field positions
  localparam int BASIC_MODE_CONTROL_LOOPBACK = 14;
  localparam int BASIC_MODE_CONTROL_SPEED    = 13;
  localparam int BASIC_MODE_CONTROL_ISOLATE  = 10;
  localparam int BASIC_MODE_CONTROL_DUPLEX   = 8;
  localparam logic [15:0] BASIC_MODE_CONTROL_WR_MASK = 16'h6500;
  localparam logic [15:0] BASIC_MODE_CONTROL_RESET   = 16'h0000;
  localparam int PHY_CONTROL_LED_LSB    = 5;
  localparam int PHY_CONTROL_PSR15      = 11;
  localparam int PHY_CONTROL_BUILT_IN_SELFTEST_START = 9;
  localparam int PHY_CONTROL_BUILT_IN_SELFTEST_STAT  = 8;
  localparam int DIAG_CONT        = 5;
  localparam int DIAG_ERR_LSB     = 8;
  localparam int STS_LOOPBACK     = 3;
  localparam int LEDOVR_EN_LSB    = 3;
  // Strap default from the pin pulls
  localparam logic [4:0] ADDR_STRAP_DEFAULT = 5'h01;
  // Timing
  localparam int LINK_PULSES_NEEDED = 7;
  localparam int LED_BLINK_MS       = 50;
  localparam int LINK_LOSS_MS       = 150;
  localparam int BLINK_HALF_CYCLES  = CLK_HZ / 1000 * LED_BLINK_MS;
  localparam int LINK_LOSS_CYCLES   = CLK_HZ / 1000 * LINK_LOSS_MS;
  // Self-test
  localparam logic [14:0] LFSR_SEED = 15'h7FFF;
  localparam int BUILT_IN_SELFTEST_BURST_MSB = 6;
  localparam int FIFO_DEPTH = 8;
  localparam int NIBBLE_W   = 4;

  typedef struct packed {
    logic [3:0] rxd;
    logic       dv;
    logic       er;
  } mii_rx_t;

  typedef enum {MD_IDLE, MD_PRE, MD_HDR, MD_TA, MD_DATA} mdio_state_t;
endpackage

// ---- rtl/phy_strap_led_diag_control.sv ----
// Strap capture, isolate, LED, duplex, loopback and self-test logic
// Operation
// - Address straps are captured into phy_control[4:0] at reset release.
// - Strapped address zero forces isolate; a management write of zero does not.
// - Unstrapped address pins resolve to 00001.
// - basic_mode_control bit 10 also selects isolate.
// - Isolate ignores MII transmit, floats MII outputs, keeps management alive.
// - Isolate sends no packet data; media keeps idles or link pulses.
// - phy_control bits 6:5 pick LED mode: x1 mode 1, 00 mode 2, 10 mode 3.
// - Link indicator steady in mode 1; blinks with activity in modes 2 and 3.
// - 10 Mb/s link after seven pulses or a valid packet; loss timer drops it.
// - Speed indicator on at 100 Mb/s, off at 10 Mb/s, every mode.
// - Activity/collision indicator shows activity in mode 1, collision in mode 2.
// - Mode 3 activity/collision indicator shows full duplex.
// - Each LED polarity follows its strap level: low strap means active high.
// - led_override_control overrides LEDs; reads return the register, not pins.
// - Half duplex asserts CRS for transmit and receive.
// - Full duplex drops collision reporting and CRS follows receive only.
// - Loopback bit routes transmit to receive, mutes media, shows status bit 3.
// - Self-test sends 9 or 15 bit pseudo-random data, checked by local LFSR.
// - Self-test status starts failed, passes on match, latches fail until restart.
// - diag_selftest_control bit 5 selects uninterrupted self-test transmit.
// - Self-test mismatches are counted in diag_selftest_control bits 15:8.
`timescale 1ns/10ps

module nibble_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
)
(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;
  wire              full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);

  assign in_ready  = !full;
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

module phy_strap_led_diag_control
  import phy_diag_pkg::*;
#(
  parameter int BLINK_HALF = BLINK_HALF_CYCLES,
  parameter int LINK_LOSS  = LINK_LOSS_CYCLES
)
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // Straps
  input  wire logic [4:0] strap_port_address,
  input  wire logic [2:0] strap_led_level,
  // MII transmit from the MAC
  input  wire logic [3:0] mii_txd,
  input  wire logic       mii_tx_en,
  // MII toward the MAC
  output logic            mii_tx_clk,
  output mii_rx_t         mii_rx,
  output logic            mii_crs,
  output logic            mii_col,
  output logic            mii_out_oe,
  // Management
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe,
  // Media side
  input  wire logic       med_link_pulse,
  input  wire logic       med_valid_packet,
  input  wire logic       med_signal_detect,
  input  wire logic       med_rx_active,
  input  wire logic [3:0] med_rx_data,
  input  wire logic       med_rx_valid,
  output logic      [3:0] med_tx_data,
  output logic            med_tx_valid,
  input  wire logic       med_tx_ready,
  output logic            med_tx_idle_fill,
  // Indicators
  output logic            link_indicator,
  output logic            speed_indicator,
  output logic            activity_collision_indicator,
  // Transmit buffer
  output logic            tx_fifo_ready
);
  // Management, MII transmit and strap pins cross in through two flops
  logic [14:0] pin_meta;
  logic [14:0] pin_sync;
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= {mdc, mdio_in, mii_tx_en, mii_txd, strap_port_address, strap_led_level};
      pin_sync <= pin_meta;
    end
  end
  wire       s_mdc     = pin_sync[14];
  wire       s_mdio    = pin_sync[13];
  wire       s_tx_en   = pin_sync[12];
  wire [3:0] s_txd     = pin_sync[11:8];
  wire [4:0] s_straps  = pin_sync[7:3];
  wire [2:0] s_led_str = pin_sync[2:0];

  // Register state
  logic [4:0]  port_addr;
  logic        strap_iso;
  logic [2:0]  led_pol;
  logic [1:0]  strap_cnt;
  logic [15:0] basic_mode_control;
  logic [1:0]  led_mode_select;
  logic        prbs_length_select;
  logic        built_in_selftest_start;
  logic        built_in_selftest_status;
  logic        err_latched;
  logic [5:0]  led_override_control;
  logic        selftest_continuous;
  logic [7:0]  err_count;
  logic        reg_wr;
  logic [4:0]  reg_addr;
  logic [15:0] wr_data;
  logic        link_up;

  wire loopback    = basic_mode_control[BASIC_MODE_CONTROL_LOOPBACK];
  wire speed100    = basic_mode_control[BASIC_MODE_CONTROL_SPEED];
  wire duplex_full = basic_mode_control[BASIC_MODE_CONTROL_DUPLEX];
  wire isolate     = strap_iso | basic_mode_control[BASIC_MODE_CONTROL_ISOLATE];
  wire ctrl_wr     = reg_wr && reg_addr == REG_PHY_CTRL;

  // Straps settle after the synchroniser, so capture waits two cycles
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strap_cnt <= 2'h0;
      port_addr <= ADDR_STRAP_DEFAULT;
      strap_iso <= 1'b0;
      led_pol   <= 3'h0;
    end
    else if (strap_cnt != 2'h3)
    begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == 2'h2)
      begin
        port_addr <= s_straps;
        strap_iso <= s_straps == 5'h00;
        led_pol   <= s_led_str;
      end
    end
    else if (ctrl_wr)
      port_addr <= wr_data[4:0];
  end

  // Software registers
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      basic_mode_control   <= BASIC_MODE_CONTROL_RESET;
      led_mode_select      <= 2'h0;
      prbs_length_select   <= 1'b0;
      built_in_selftest_start           <= 1'b0;
      led_override_control <= 6'h00;
      selftest_continuous  <= 1'b0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        REG_BASIC_MODE: basic_mode_control <= wr_data & BASIC_MODE_CONTROL_WR_MASK;
        REG_LED_OVR:    led_override_control <= wr_data[5:0];
        REG_DIAG:       selftest_continuous <= wr_data[DIAG_CONT];
        REG_PHY_CTRL:
        begin
          led_mode_select    <= wr_data[PHY_CONTROL_LED_LSB+1:PHY_CONTROL_LED_LSB];
          prbs_length_select <= wr_data[PHY_CONTROL_PSR15];
          built_in_selftest_start         <= wr_data[PHY_CONTROL_BUILT_IN_SELFTEST_START];
        end
        default: ;
      endcase
    end
  end

  // Management frames: sampled on rising MDC, answered after it
  mdio_state_t md_state;
  logic        mdc_d;
  logic [4:0]  md_cnt;
  logic [12:0] md_hdr;
  logic [15:0] md_shift;
  logic        md_own;
  logic        md_rd;
  logic [15:0] rd_data;
  wire         mdc_rise = s_mdc & !mdc_d;
  wire [12:0]  hdr_next = {md_hdr[11:0], s_mdio};
  wire         hdr_read = hdr_next[11:10] == 2'b10;
  wire         hdr_wr   = hdr_next[11:10] == 2'b01;
  wire         hdr_own  = hdr_next[12] && hdr_next[9:5] == port_addr;

  assign rd_data =
      reg_addr == REG_BASIC_MODE ? basic_mode_control :
      reg_addr == REG_STATUS ? {12'h000, loopback, duplex_full, !speed100, link_up} :
      reg_addr == REG_LED_OVR ? {10'h000, led_override_control} :
      reg_addr == REG_PHY_CTRL ? {4'h0, prbs_length_select, 1'b0, built_in_selftest_start,
                                  built_in_selftest_status, 1'b0, led_mode_select, port_addr} :
      reg_addr == REG_DIAG ? {err_count, 2'h0, selftest_continuous, 5'h00} :
      16'h0000;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      md_state <= MD_IDLE;
      mdc_d    <= 1'b0;
      md_cnt   <= 5'h00;
      md_hdr   <= 13'h0000;
      md_shift <= 16'h0000;
      md_own   <= 1'b0;
      md_rd    <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
      reg_wr   <= 1'b0;
      reg_addr <= 5'h00;
      wr_data  <= 16'h0000;
    end
    else
    begin
      mdc_d  <= s_mdc;
      reg_wr <= 1'b0;
      if (mdc_rise)
      begin
        case (md_state)
          MD_IDLE: if (s_mdio) md_state <= MD_PRE;
          MD_PRE:
            if (!s_mdio)
            begin
              md_state <= MD_HDR;
              md_cnt   <= 5'h00;
            end
          MD_HDR:
          begin
            md_hdr <= hdr_next;
            md_cnt <= md_cnt + 5'h01;
            if (md_cnt == 5'd12)
            begin
              md_state <= MD_TA;
              md_cnt   <= 5'h00;
              md_own   <= hdr_own & (hdr_read | hdr_wr);
              md_rd    <= hdr_read;
              reg_addr <= hdr_next[4:0];
            end
          end
          MD_TA:
          begin
            md_cnt <= md_cnt + 5'h01;
            if (md_own && md_rd)
            begin
              mdio_oe  <= 1'b1;
              mdio_out <= md_cnt == 5'h00 ? 1'b0 : rd_data[15];
              md_shift <= {rd_data[14:0], 1'b0};
            end
            if (md_cnt == 5'h01)
            begin
              md_state <= MD_DATA;
              md_cnt   <= 5'h00;
            end
          end
          MD_DATA:
          begin
            md_cnt <= md_cnt + 5'h01;
            if (md_rd)
            begin
              mdio_out <= md_shift[15];
              md_shift <= {md_shift[14:0], 1'b0};
            end
            else
              md_shift <= {md_shift[14:0], s_mdio};
            if (md_cnt == 5'd15)
            begin
              md_state <= MD_IDLE;
              mdio_oe  <= 1'b0;
              reg_wr   <= md_own & !md_rd;
              wr_data  <= {md_shift[14:0], s_mdio};
            end
          end
          default: md_state <= MD_IDLE;
        endcase
      end
    end
  end

  // Self-test generator and checker
  logic [14:0] gen_lfsr;
  logic [14:0] chk_lfsr;
  logic [6:0]  burst_cnt;
  logic        fifo_out_valid;
  logic [3:0]  fifo_out_data;

  function automatic logic [14:0] lfsr_step4(input logic [14:0] s, input logic p15);
    logic [14:0] v;
    v = s;
    for (int i = 0; i < 4; i++)
      v = p15 ? {v[13:0], v[14] ^ v[13]} : {6'h00, v[7:0], v[8] ^ v[4]};
    return v;
  endfunction

  wire       gen_valid  = selftest_continuous | !burst_cnt[BUILT_IN_SELFTEST_BURST_MSB];
  wire       tx_active  = s_tx_en & !isolate;
  wire [3:0] src_data   = built_in_selftest_start ? gen_lfsr[3:0] : s_txd;
  wire       src_valid  = built_in_selftest_start ? gen_valid : tx_active;
  wire [3:0] rx_word    = loopback ? fifo_out_data : med_rx_data;
  wire       rx_wvalid  = loopback ? fifo_out_valid : med_rx_valid;
  wire       chk_valid  = built_in_selftest_start & rx_wvalid;
  wire       miscompare = chk_valid && rx_word != chk_lfsr[3:0];

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gen_lfsr    <= LFSR_SEED;
      chk_lfsr    <= LFSR_SEED;
      burst_cnt   <= 7'h00;
      built_in_selftest_status <= 1'b0;
      err_latched <= 1'b0;
      err_count   <= 8'h00;
    end
    else
    begin
      if (!built_in_selftest_start)
      begin
        gen_lfsr  <= LFSR_SEED;
        chk_lfsr  <= LFSR_SEED;
        burst_cnt <= 7'h00;
      end
      else
      begin
        burst_cnt <= burst_cnt + 7'h01;
        if (gen_valid && tx_fifo_ready)
          gen_lfsr <= lfsr_step4(gen_lfsr, prbs_length_select);
        if (chk_valid)
          chk_lfsr <= lfsr_step4(chk_lfsr, prbs_length_select);
      end
      if (miscompare)
        built_in_selftest_status <= 1'b0;
      else if (chk_valid && !err_latched && !ctrl_wr)
        built_in_selftest_status <= 1'b1;
      if (ctrl_wr)
        err_latched <= miscompare;
      else if (miscompare)
        err_latched <= 1'b1;
      if (ctrl_wr)
        err_count <= {7'h00, miscompare};
      else if (miscompare && err_count != 8'hFF)
        err_count <= err_count + 8'h01;
    end
  end

  // Transmit buffer; loopback drains it to the MII receive side
  nibble_fifo #(.WIDTH(NIBBLE_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .in_valid  (src_valid),
    .in_data   (src_data),
    .in_ready  (tx_fifo_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (loopback | med_tx_ready)
  );
  assign med_tx_data      = fifo_out_data;
  assign med_tx_valid     = fifo_out_valid & !loopback & !isolate;
  assign med_tx_idle_fill = !med_tx_valid;

  // Link detection at 10 Mb/s
  logic [23:0] loss_cnt;
  logic [2:0]  nlp_cnt;
  logic        link_10;
  wire         loss_out = loss_cnt == 24'(LINK_LOSS - 1);
  assign link_up = speed100 ? med_signal_detect : link_10;
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      loss_cnt <= 24'h000000;
      nlp_cnt  <= 3'h0;
      link_10  <= 1'b0;
    end
    else if (med_valid_packet)
    begin
      loss_cnt <= 24'h000000;
      link_10  <= 1'b1;
    end
    else if (med_link_pulse)
    begin
      loss_cnt <= 24'h000000;
      if (nlp_cnt == 3'(LINK_PULSES_NEEDED - 1))
        link_10 <= 1'b1;
      else
        nlp_cnt <= nlp_cnt + 3'h1;
    end
    else if (loss_out)
    begin
      nlp_cnt <= 3'h0;
      link_10 <= 1'b0;
    end
    else
      loss_cnt <= loss_cnt + 24'h000001;
  end

  // Duplex-dependent carrier and collision
  wire rx_active = loopback ? fifo_out_valid : med_rx_active;
  wire col_now   = !duplex_full & tx_active & rx_active;
  wire crs_now   = rx_active | (!duplex_full & tx_active);
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mii_rx     <= '0;
      mii_crs    <= 1'b0;
      mii_col    <= 1'b0;
      mii_tx_clk <= 1'b0;
    end
    else
    begin
      mii_rx     <= '{rxd: rx_word, dv: rx_wvalid, er: 1'b0};
      mii_crs    <= crs_now;
      mii_col    <= col_now;
      mii_tx_clk <= !mii_tx_clk;
    end
  end
  assign mii_out_oe = !isolate;

  // Blink rate; slow enough to see, far too slow to simulate at full value
  logic [23:0] blink_cnt;
  logic        blink_phase;
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      blink_cnt   <= 24'h000000;
      blink_phase <= 1'b0;
    end
    else if (blink_cnt == 24'(BLINK_HALF - 1))
    begin
      blink_cnt   <= 24'h000000;
      blink_phase <= !blink_phase;
    end
    else
      blink_cnt <= blink_cnt + 24'h000001;
  end

  // LED selection, override and polarity
  wire       activity = tx_active | rx_active;
  wire       mode1    = led_mode_select[0];
  wire       mode3    = led_mode_select[1] & !led_mode_select[0];
  wire       link_ind = mode1 ? link_up : link_up & !(activity & blink_phase);
  wire       act_ind  = mode1 ? activity : (mode3 ? duplex_full : col_now);
  wire [2:0] led_val  = {act_ind, speed100, link_ind};
  logic [2:0] led_q;
  for (genvar i = 0; i < 3; i++)
  begin : g_led
    wire drive = led_override_control[LEDOVR_EN_LSB + i] ? led_override_control[i]
                                                          : led_val[i];
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
      if (!arst_n)
        led_q[i] <= 1'b0;
      else
        led_q[i] <= drive ^ led_pol[i];
    end
  end
  assign link_indicator    = led_q[0];
  assign speed_indicator   = led_q[1];
  assign activity_collision_indicator = led_q[2];

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  AST_ISOLATE_FLOATS: assert property (isolate |-> !mii_out_oe && !med_tx_valid)
    else $error("isolate leaves MII driven");
  AST_ZERO_WRITE_NO_ISO: assert property (ctrl_wr && wr_data[4:0] == 5'h00 && !isolate
      && !basic_mode_control[BASIC_MODE_CONTROL_ISOLATE] |=> !isolate)
    else $error("address write entered isolate");
  AST_FULL_NO_COL: assert property (duplex_full && $past(duplex_full) |-> !mii_col)
    else $error("collision in full duplex");
  AST_HALF_CRS_TX: assert property (!duplex_full && tx_active |=> mii_crs)
    else $error("no carrier on half duplex transmit");
  AST_LOOP_MUTE: assert property (loopback |-> !med_tx_valid)
    else $error("media fed during loopback");
  AST_LINK_SEVEN: assert property ($rose(link_10) |-> $past(med_valid_packet)
      || $past(med_link_pulse) && $past(nlp_cnt) == 3'h6)
    else $error("link declared early");
  AST_BUILT_IN_SELFTEST_LATCH: assert property (err_latched && !ctrl_wr |=> err_latched && !built_in_selftest_status)
    else $error("fail latch lost");
  AST_ERR_COUNT: assert property (miscompare && !ctrl_wr && err_count != 8'hFF
      |=> err_count == $past(err_count) + 8'h01)
    else $error("mismatch not counted");
  // Polarity is taken from the edge that loaded the pin, as it moves at strap capture
  AST_SPEED_LED: assert property (!led_override_control[LEDOVR_EN_LSB + 1] ##1
      !led_override_control[LEDOVR_EN_LSB + 1]
      |-> speed_indicator == ($past(speed100) ^ $past(led_pol[1])))
    else $error("speed indicator wrong");
  AST_MODE3_DUPLEX: assert property (mode3 && !led_override_control[LEDOVR_EN_LSB + 2]
      && $stable(led_override_control)
      |=> activity_collision_indicator == ($past(duplex_full) ^ $past(led_pol[2])))
    else $error("mode 3 duplex indicator wrong");

  COV_ISOLATE: cover property (isolate ##1 !isolate);
  COV_LOOPBACK: cover property (loopback && fifo_out_valid);
  COV_MISCOMPARE: cover property (miscompare ##1 ctrl_wr);
  COV_MDIO_WRITE: cover property (reg_wr && reg_addr == REG_LED_OVR);
endmodule

// ---- verif/mac_model.sv ----
// MAC-side model driving MII transmit nibbles
`timescale 1ns/10ps
module mac_model
(
  // Clock
  input  wire logic       clk_sys,
  // MII transmit
  output logic      [3:0] mii_txd,
  output logic            mii_tx_en
);
  initial
  begin
    mii_txd   = 4'h0;
    mii_tx_en = 1'b0;
  end
  // Idle data is inverted so a stale nibble never looks valid
  task automatic drive(input logic en, input logic [3:0] n);
  begin
    @(negedge clk_sys);
    mii_tx_en = en;
    mii_txd   = en ? n : ~mii_txd;
  end
  endtask
endmodule

// ---- verif/tb_phy_strap_led_diag_control.sv ----
// Self-checking bench for the strap, LED and diagnostic block
`timescale 1ns/10ps
module tb_phy_strap_led_diag_control
  import phy_diag_pkg::*;
;
  logic        clk_sys, arst_n, mdc, mst, mdio_wire, mdio_out, mdio_oe;
  logic [4:0]  strap_a;
  logic [2:0]  strap_l;
  logic [3:0]  mii_txd, med_rxd, med_tx_data, nb;
  logic        mii_tx_en, mii_tx_clk, mii_crs, mii_col, mii_out_oe;
  mii_rx_t     mii_rx;
  logic        med_sd, med_act, med_tx_valid, med_tx_ready, med_tx_idle_fill;
  logic        med_lp, med_vp, med_rxv;
  logic        link_indicator, speed_indicator, activity_collision_indicator, tx_fifo_ready;
  logic [15:0] rd;
  logic [3:0]  exp_q[$];
  int          error_cnt, checks_done, seed, k;

  assign mdio_wire = mdio_oe ? mdio_out : mst;

  phy_strap_led_diag_control #(.BLINK_HALF(8), .LINK_LOSS(20)) phy_strap_led_diag_control_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .strap_port_address(strap_a),
    .strap_led_level(strap_l), .mii_txd(mii_txd), .mii_tx_en(mii_tx_en),
    .mii_tx_clk(mii_tx_clk), .mii_rx(mii_rx), .mii_crs(mii_crs), .mii_col(mii_col),
    .mii_out_oe(mii_out_oe), .mdc(mdc), .mdio_in(mdio_wire), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .med_link_pulse(med_lp), .med_valid_packet(med_vp),
    .med_signal_detect(med_sd), .med_rx_active(med_act), .med_rx_data(med_rxd),
    .med_rx_valid(med_rxv), .med_tx_data(med_tx_data), .med_tx_valid(med_tx_valid),
    .med_tx_ready(med_tx_ready), .med_tx_idle_fill(med_tx_idle_fill),
    .link_indicator(link_indicator), .speed_indicator(speed_indicator), .activity_collision_indicator(activity_collision_indicator),
    .tx_fifo_ready(tx_fifo_ready));

  mac_model mac_model_i (.clk_sys(clk_sys), .mii_txd(mii_txd), .mii_tx_en(mii_tx_en));

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic print_verdict;
  begin
    if (error_cnt == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
  begin
    checks_done++;
    if (s !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  end
  endtask

  // One management frame; the released line reads high through its pull-up
  task automatic mdio(input logic wr, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rdv);
    logic [33:0] f;
    logic        s;
    f   = {4'b1101, wr ? 2'b01 : 2'b10, pa, ra, wr ? 2'b10 : 2'b11, wr ? wd : 16'hFFFF};
    rdv = 16'h0000;
    for (int i = 33; i >= 0; i--)
    begin
      mst = f[i];
      repeat (4) @(negedge clk_sys);
      s   = mdio_wire;
      mdc = 1'b1;
      repeat (4) @(negedge clk_sys);
      mdc = 1'b0;
      rdv = {rdv[14:0], s};
    end
    mst = 1'b1;
    repeat (8) @(negedge clk_sys);
  endtask

  // Random stall on the media side
  always @(negedge clk_sys)
    med_tx_ready <= 1'($random(seed));

  always @(negedge clk_sys)
    if (mii_rx.dv === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("rx_extra", 16'h0000, 16'h0001);
      else
        chk("loop_rxd", 16'(exp_q.pop_front()), 16'(mii_rx.rxd));
    end

  initial
  begin
    seed = 36;
    error_cnt = 0;
    checks_done = 0;
    arst_n = 1'b0;
    mdc = 1'b0;
    mst = 1'b1;
    strap_a = 5'h05;
    strap_l = 3'b010;
    med_sd = 1'b0;
    med_act = 1'b0;
    med_rxd = 4'h0;
    med_lp = 1'b0;
    med_vp = 1'b0;
    med_rxv = 1'b0;
    repeat (2) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    mdio(0, 5'h05, REG_PHY_CTRL, 16'h0000, rd);
    chk("port_addr", 16'h0005, 16'(rd[4:0]));
    mdio(0, 5'h05, REG_BASIC_MODE, 16'h0000, rd);
    chk("basic_mode", BASIC_MODE_CONTROL_RESET, rd);
    mdio(0, 5'h05, 5'h05, 16'h0000, rd);
    chk("unmapped", 16'h0000, rd);
    chk("speed_indicator_10", 16'h0001, 16'(speed_indicator));
    mdio(1, 5'h05, REG_BASIC_MODE, 16'h2000, rd);
    chk("speed_indicator_100", 16'h0000, 16'(speed_indicator));
    mdio(1, 5'h05, REG_BASIC_MODE, 16'h0400, rd);
    chk("isolate_oe", 16'h0000, 16'(mii_out_oe));
    mdio(0, 5'h05, REG_BASIC_MODE, 16'h0000, rd);
    chk("isolate_mgmt", 16'h0400, rd);
    mdio(1, 5'h05, REG_BASIC_MODE, 16'h0000, rd);
    mac_model_i.drive(1'b1, 4'hA);
    repeat (5) @(negedge clk_sys);
    chk("crs_half_tx", 16'h0001, 16'(mii_crs));
    mdio(1, 5'h05, REG_BASIC_MODE, 16'h0100, rd);
    chk("crs_full_tx", 16'h0000, 16'(mii_crs));
    med_act = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("crs_full_rx", 16'h0001, 16'(mii_crs));
    chk("col_full", 16'h0000, 16'(mii_col));
    med_act = 1'b0;
    mac_model_i.drive(1'b0, 4'h0);
    mdio(1, 5'h05, REG_BASIC_MODE, 16'h4100, rd);
    for (int i = 0; i < 6; i++)
    begin
      nb = 4'($random(seed));
      exp_q.push_back(nb);
      mac_model_i.drive(1'b1, nb);
    end
    mac_model_i.drive(1'b0, 4'h0);
    for (k = 0; k < 40 && exp_q.size() != 0; k++)
      @(negedge clk_sys);
    if (exp_q.size() != 0)
    begin
      chk("loop_drain", 16'h0000, 16'(exp_q.size()));
      exp_q.delete();
    end
    mdio(0, 5'h05, REG_STATUS, 16'h0000, rd);
    chk("loop_status", 16'h0001, 16'(rd[STS_LOOPBACK]));
    mdio(1, 5'h05, REG_BASIC_MODE, 16'h0100, rd);
    // Pulses four cycles apart stay well inside the shortened loss timer
    for (int i = 0; i < 7; i++)
    begin
      if (i == 6)
        chk("link_six", 16'h0000, 16'(link_indicator));
      med_lp = 1'b1;
      @(negedge clk_sys);
      med_lp = 1'b0;
      repeat (3) @(negedge clk_sys);
    end
    chk("link_seven", 16'h0001, 16'(link_indicator));
    repeat (30) @(negedge clk_sys);
    chk("link_lost", 16'h0000, 16'(link_indicator));
    med_vp = 1'b1;
    @(negedge clk_sys);
    med_vp = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("link_packet", 16'h0001, 16'(link_indicator));
    mdio(1, 5'h05, REG_PHY_CTRL, 16'h0A45, rd);
    chk("led_mode3", 16'h0001, 16'(activity_collision_indicator));
    // First nibble of either sequence is F, the second is 0, so F twice fails once
    med_rxd = 4'hF;
    for (int i = 0; i < 2; i++)
    begin
      exp_q.push_back(4'hF);
      med_rxv = 1'b1;
      @(negedge clk_sys);
      med_rxv = 1'b0;
      mdio(0, 5'h05, REG_PHY_CTRL, 16'h0000, rd);
      chk("built_in_selftest_status", i == 0 ? 16'h0B45 : 16'h0A45, rd);
    end
    mdio(1, 5'h05, REG_DIAG, 16'h0020, rd);
    mdio(0, 5'h05, REG_DIAG, 16'h0000, rd);
    chk("diag", 16'h0120, rd);
    mdio(1, 5'h05, REG_LED_OVR, 16'h0009, rd);
    chk("link_indicator_ovr", 16'h0001, 16'(link_indicator));
    mdio(0, 5'h05, REG_LED_OVR, 16'h0000, rd);
    chk("led_ovr_read", 16'h0009, rd);
    mdio(1, 5'h05, REG_PHY_CTRL, 16'h0020, rd);
    mdio(0, 5'h00, REG_PHY_CTRL, 16'h0000, rd);
    chk("addr_zero", 16'h0000, 16'(rd[4:0]));
    chk("addr_zero_oe", 16'h0001, 16'(mii_out_oe));
    med_act = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("led_mode1_act", 16'h0001, 16'(activity_collision_indicator));
    print_verdict;
  end
endmodule
